// file: verilog/serial_port_pkg.sv
/*
 * Constants shared by the serial port control block and its baud
 * generator: register indices, field positions, reset values, counts.
 * Assumes a 25 MHz pclk and an APB master that addresses each register
 * by word: byte address = index * 4.
 */
// Function
// RULE_01 - tx_irq_en requests interrupt while buffer empty
// RULE_02 - tx_done_irq_en requests interrupt while tx done
// RULE_03 - rx_irq_en requests interrupt on overrun or full
// RULE_04 - idle_irq_en requests interrupt on idle line
// RULE_05 - One bit-time delay after tx_on set
// RULE_06 - tx_on toggle mid-word sends idle preamble after
// RULE_07 - Pin released only when both enables clear; code also releases it until tx_on has first been set
// RULE_08 - rx_on enables start bit search
// RULE_09 - Receive data before setting rx_mute
// RULE_10 - rx_mute selects mute; hardware clears on wakeup
// RULE_11 - break_request sends breaks; falling edge sends one
// RULE_12 - Data address splits into tx and rx buffers
// RULE_13 - first_prescale_sel picks coarse factor 1,3,4,13
// RULE_14 - tx_rate_sel gives tx factor two to the field
// RULE_15 - rx_rate_sel gives rx factor two to the field
// RULE_16 - Nonzero rx_ext_divisor divides the sixteen stage
// RULE_17 - Extended receive divider bypassed after reset
// RULE_18 - tx_ext_divisor works likewise for transmit
// RULE_19 - Status read then data access clears flags
// RULE_20 - Plain baud is pclk over coarse, factor, 16
package serial_port_pkg;

  // ****************************************************************
  // Register indices
  // ****************************************************************
  localparam logic [7:0] IDX_STATUS = 8'h50;
  localparam logic [7:0] IDX_DATA   = 8'h51;
  localparam logic [7:0] IDX_BAUD   = 8'h52;
  localparam logic [7:0] IDX_CTRL_A = 8'h53;
  localparam logic [7:0] IDX_CTRL_B = 8'h54;
  localparam logic [7:0] IDX_RX_EXT = 8'h55;
  localparam logic [7:0] IDX_TX_EXT = 8'h57;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CB_TX_IRQ_EN   = 7;
  localparam int CB_DONE_IRQ_EN = 6;
  localparam int CB_RX_IRQ_EN   = 5;
  localparam int CB_IDLE_IRQ_EN = 4;
  localparam int CB_TX_ON       = 3;
  localparam int CB_RX_ON       = 2;
  localparam int CB_RX_MUTE     = 1;
  localparam int CB_BREAK_REQ   = 0;
  localparam int CA_WAKE_SEL    = 3;
  localparam int BR_PRE_LSB     = 6;
  localparam int BR_TX_LSB      = 3;
  localparam int BR_RX_LSB      = 0;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] BAUD_RST = 8'h00;
  localparam logic [7:0] EXT_RST  = 8'h00;

  // ****************************************************************
  // Counts and codes
  // ****************************************************************
  localparam logic [3:0] FRAME_LAST = 4'h9;
  localparam logic [3:0] OS_LAST    = 4'hf;
  localparam logic [3:0] START_MID  = 4'h7;
  localparam logic [2:0] DATA_LAST  = 3'h7;
  localparam logic [7:0] IDLE_LAST  = 8'h9f;
  localparam logic [9:0] FRAME_MARK = 10'h3ff;
  localparam logic [9:0] FRAME_SPACE = 10'h000;
  localparam logic [3:0] COARSE_0   = 4'h1;
  localparam logic [3:0] COARSE_1   = 4'h3;
  localparam logic [3:0] COARSE_2   = 4'h4;
  localparam logic [3:0] COARSE_3   = 4'hd;

endpackage

// file: verilog/baud_gen.sv
/*
 * Baud tick generator: oversample tick at sixteen per bit and a bit tick.
 * Assumes the selects come straight from registers on the same clock.
 */
`timescale 1ns/1ps
module baud_gen (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       ce,
  input  wire logic [1:0] prescale_sel,
  input  wire logic [2:0] rate_sel,
  input  wire logic [7:0] ext_div,
  output logic            os_tick,
  output logic            bit_tick
);

  typedef struct packed {
    logic [18:0] cnt;
    logic [3:0]  sub;
    logic        os;
    logic        bt;
  } bg_state_t;

  bg_state_t s;
  bg_state_t n;
  logic [18:0] span;
  logic [7:0]  ext_eff;

  function automatic logic [3:0] coarse(input logic [1:0] sel);
    logic [3:0] f;
    f = serial_port_pkg::COARSE_0;
    unique case (sel)
      2'h0: f = serial_port_pkg::COARSE_0;
      2'h1: f = serial_port_pkg::COARSE_1;
      2'h2: f = serial_port_pkg::COARSE_2;
      2'h3: f = serial_port_pkg::COARSE_3;
    endcase
    return f;
  endfunction

  // ****************************************************************
  // Divider chain
  // ****************************************************************
  always_comb
  begin
    ext_eff = (ext_div == 8'h00) ? 8'h01 : ext_div;  // see RULE_16
    span = 19'(19'(coarse(prescale_sel)) * 19'(ext_eff))
           << rate_sel;  // see RULE_13 see RULE_14 see RULE_15
    n = s;
    n.os = 1'b0;
    n.bt = 1'b0;
    if (s.cnt >= span - 19'h00001)
    begin
      n.cnt = 19'h00000;
      n.os = 1'b1;
      n.sub = s.sub + 4'h1;
      n.bt = (s.sub == serial_port_pkg::OS_LAST);  // see RULE_20
    end
    else
    begin
      n.cnt = s.cnt + 19'h00001;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s <= '0;
    else if (ce)
      s <= n;
  end

  assign os_tick = s.os;
  assign bit_tick = s.bt;

endmodule

// file: verilog/serial_port.sv
/*
 * Serial port control block: APB register file, transmitter with break
 * and preamble, receiver with mute wakeup, interrupt request.
 * Assumes an APB master on pclk and an asynchronous line on rxd_pin.
 */
`timescale 1ns/1ps
module serial_port (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rxd_pin,
  output logic             txd_out,
  output logic             txd_oe,
  output logic             irq
);

  typedef enum logic [1:0] {TX_OFF, TX_DELAY, TX_READY, TX_SHIFT} tx_st_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_st_t;

  typedef struct packed {
    logic [7:0]  ctrl_a;
    logic [7:0]  ctrl_b;
    logic [7:0]  baud;
    logic [7:0]  rx_ext;
    logic [7:0]  tx_ext;
    logic [7:0]  tx_buf;
    logic [7:0]  rx_buf;
    logic        tx_buffer_empty_flag;
    logic        tc;
    logic        rx_full_flag;
    logic        idle;
    logic        ovr;
    logic        fe;
    logic        armed;
    logic        capt;
    logic [31:0] rdata;
    logic [2:0]  rx_sync;
    logic        rx_line;
    tx_st_t      tx_st;
    logic [9:0]  tx_frame;
    logic [3:0]  tx_left;
    logic        tx_q;
    logic        ton_d;
    logic        brk_d;
    logic        pre_pend;
    logic        brk_pend;
    logic        tx_ever;
    rx_st_t      rx_st;
    logic [3:0]  os_cnt;
    logic [2:0]  bit_cnt;
    logic [7:0]  rx_sh;
    logic [7:0]  idle_cnt;
    logic        idle_armed;
  } state_t;

  state_t s;
  state_t n;

  logic       os_tick;
  logic       bit_tick;
  logic       xfer;
  logic       wr;
  logic       rd;
  logic [7:0] idx;
  logic       ton;
  logic       ron;
  logic       brq;
  logic       mute;
  logic       can_load;
  logic       loaded;
  logic       wake;
  logic [7:0] status;

  function automatic logic mapped(input logic [11:0] a);
    logic [7:0] i;
    i = a[9:2];
    return (a[11:10] == 2'h0) &&
           (i == serial_port_pkg::IDX_STATUS ||
            i == serial_port_pkg::IDX_DATA ||
            i == serial_port_pkg::IDX_BAUD ||
            i == serial_port_pkg::IDX_CTRL_A ||
            i == serial_port_pkg::IDX_CTRL_B ||
            i == serial_port_pkg::IDX_RX_EXT ||
            i == serial_port_pkg::IDX_TX_EXT);
  endfunction

  // ****************************************************************
  // Baud generators
  // ****************************************************************
  baud_gen u_tx_baud (
    .pclk         (pclk),
    .presetn      (presetn),
    .ce           (ce),
    .prescale_sel (s.baud[serial_port_pkg::BR_PRE_LSB +: 2]),
    .rate_sel     (s.baud[serial_port_pkg::BR_TX_LSB +: 3]),
    .ext_div      (s.tx_ext),  // see RULE_18
    .os_tick      (),
    .bit_tick     (bit_tick)
  );

  baud_gen u_rx_baud (
    .pclk         (pclk),
    .presetn      (presetn),
    .ce           (ce),
    .prescale_sel (s.baud[serial_port_pkg::BR_PRE_LSB +: 2]),
    .rate_sel     (s.baud[serial_port_pkg::BR_RX_LSB +: 3]),
    .ext_div      (s.rx_ext),  // see RULE_16
    .os_tick      (os_tick),
    .bit_tick     ()
  );

  // ****************************************************************
  // Decode and outputs
  // ****************************************************************
  assign idx = paddr[9:2];
  assign ton = s.ctrl_b[serial_port_pkg::CB_TX_ON];
  assign ron = s.ctrl_b[serial_port_pkg::CB_RX_ON];
  assign brq = s.ctrl_b[serial_port_pkg::CB_BREAK_REQ];
  assign mute = s.ctrl_b[serial_port_pkg::CB_RX_MUTE];
  assign status = {s.tx_buffer_empty_flag, s.tc, s.rx_full_flag, s.idle, s.ovr, 1'b0, s.fe, 1'b0};

  assign pready = psel & penable & ce & s.capt;
  assign pslverr = pready & ~mapped(paddr);
  assign xfer = pready;
  assign wr = xfer & pwrite & mapped(paddr);
  assign rd = xfer & ~pwrite & mapped(paddr);
  assign prdata = s.rdata;
  assign txd_out = s.tx_q;
  assign txd_oe = s.tx_ever & (ton | ron);  // see RULE_07

  always_comb
  begin
    irq = (s.ctrl_b[serial_port_pkg::CB_TX_IRQ_EN] & s.tx_buffer_empty_flag)    // see RULE_01
        | (s.ctrl_b[serial_port_pkg::CB_DONE_IRQ_EN] & s.tc)    // see RULE_02
        | (s.ctrl_b[serial_port_pkg::CB_RX_IRQ_EN]
           & (s.ovr | s.rx_full_flag))                                 // see RULE_03
        | (s.ctrl_b[serial_port_pkg::CB_IDLE_IRQ_EN] & s.idle); // see RULE_04
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    n = s;
    can_load = 1'b0;
    loaded = 1'b0;
    wake = 1'b0;

    // Bus side: reads capture data, clears come before hardware sets
    n.capt = psel & ~xfer;
    if (psel & ~pwrite & ~xfer)
    begin
      unique case (idx)
        serial_port_pkg::IDX_STATUS: n.rdata = {24'h000000, status};
        serial_port_pkg::IDX_DATA:   n.rdata = {24'h000000, s.rx_buf};
        serial_port_pkg::IDX_BAUD:   n.rdata = {24'h000000, s.baud};
        serial_port_pkg::IDX_CTRL_A: n.rdata = {24'h000000, s.ctrl_a};
        serial_port_pkg::IDX_CTRL_B: n.rdata = {24'h000000, s.ctrl_b};
        serial_port_pkg::IDX_RX_EXT: n.rdata = {24'h000000, s.rx_ext};
        serial_port_pkg::IDX_TX_EXT: n.rdata = {24'h000000, s.tx_ext};
        default:                     n.rdata = 32'h00000000;
      endcase
    end
    if (rd & (idx == serial_port_pkg::IDX_STATUS))
      n.armed = 1'b1;
    if ((rd | wr) & (idx == serial_port_pkg::IDX_DATA) & s.armed)
    begin
      n.armed = 1'b0;
      n.rx_full_flag = 1'b0;  // see RULE_19
      n.idle = 1'b0;
      n.ovr = 1'b0;
      n.fe = 1'b0;
      if (wr)
        n.tc = 1'b0;
    end
    if (wr)
    begin
      unique case (idx)
        serial_port_pkg::IDX_DATA:
        begin
          n.tx_buf = pwdata[7:0];  // see RULE_12
          n.tx_buffer_empty_flag = 1'b0;
        end
        serial_port_pkg::IDX_BAUD:   n.baud = pwdata[7:0];
        serial_port_pkg::IDX_CTRL_A: n.ctrl_a = {1'b0, pwdata[6:0]};
        serial_port_pkg::IDX_CTRL_B: n.ctrl_b = pwdata[7:0];
        serial_port_pkg::IDX_RX_EXT: n.rx_ext = pwdata[7:0];
        serial_port_pkg::IDX_TX_EXT: n.tx_ext = pwdata[7:0];
        default:                     n.rx_ext = s.rx_ext;
      endcase
    end

    // Transmitter
    n.ton_d = ton;
    n.brk_d = brq;
    if (ton)
      n.tx_ever = 1'b1;
    if (~brq & s.brk_d & (s.tx_st == TX_SHIFT))
      n.brk_pend = 1'b1;  // see RULE_11
    unique case (s.tx_st)
      TX_OFF:
      begin
        n.tx_q = 1'b1;
        if (ton & ~s.ton_d)
          n.tx_st = TX_DELAY;
      end
      TX_DELAY:
      begin
        if (~ton)
          n.tx_st = TX_OFF;
        else if (bit_tick)
          n.tx_st = TX_READY;  // see RULE_05
      end
      TX_READY:
      begin
        if (~ton)
          n.tx_st = TX_OFF;
        else
          can_load = bit_tick;
      end
      TX_SHIFT:
      begin
        if (ton & ~s.ton_d)
          n.pre_pend = 1'b1;  // see RULE_06
        if (bit_tick)
        begin
          if (s.tx_left == 4'h0)
          begin
            n.tx_q = 1'b1;
            n.tx_st = ton ? TX_READY : TX_OFF;
            can_load = ton;
            n.tc = s.tx_buffer_empty_flag & ~s.pre_pend & ~s.brk_pend & ~brq;
          end
          else
          begin
            n.tx_q = s.tx_frame[0];
            n.tx_frame = {1'b1, s.tx_frame[9:1]};
            n.tx_left = s.tx_left - 4'h1;
          end
        end
      end
    endcase
    if (can_load)
    begin
      loaded = 1'b1;
      if (brq | s.brk_pend)
      begin
        n.tx_frame = serial_port_pkg::FRAME_SPACE;  // see RULE_11
        n.brk_pend = 1'b0;
      end
      else if (s.pre_pend | n.pre_pend)
      begin
        n.tx_frame = serial_port_pkg::FRAME_MARK;  // see RULE_06
        n.pre_pend = 1'b0;
      end
      else if (~s.tx_buffer_empty_flag)
      begin
        n.tx_frame = {1'b1, s.tx_buf, 1'b0};  // see RULE_12
        n.tx_buffer_empty_flag = 1'b1;
      end
      else
        loaded = 1'b0;
    end
    if (loaded)
    begin
      n.tc = 1'b0;
      n.tx_q = n.tx_frame[0];
      n.tx_frame = {1'b1, n.tx_frame[9:1]};
      n.tx_left = serial_port_pkg::FRAME_LAST;
      n.tx_st = TX_SHIFT;
    end

    // Receiver: three-stage synchroniser, change taken when the last two stages agree
    n.rx_sync = {s.rx_sync[1:0], rxd_pin};
    if (s.rx_sync[2] == s.rx_sync[1])
      n.rx_line = s.rx_sync[2];
    if (~ron)
    begin
      n.rx_st = RX_IDLE;  // see RULE_08
      n.idle_cnt = 8'h00;
    end
    else if (os_tick)
    begin
      unique case (s.rx_st)
        RX_IDLE:
        begin
          if (~s.rx_line)
          begin
            n.rx_st = RX_START;
            n.os_cnt = 4'h0;
            n.idle_cnt = 8'h00;
          end
          else if (s.idle_armed)
          begin
            if (s.idle_cnt == serial_port_pkg::IDLE_LAST)
            begin
              n.idle_armed = 1'b0;  // see RULE_09
              if (mute & ~s.ctrl_a[serial_port_pkg::CA_WAKE_SEL])
                n.ctrl_b[serial_port_pkg::CB_RX_MUTE] = 1'b0;  // see RULE_10
              else if (~mute)
                n.idle = 1'b1;
            end
            else
              n.idle_cnt = s.idle_cnt + 8'h01;
          end
        end
        RX_START:
        begin
          if (s.rx_line)
            n.rx_st = RX_IDLE;
          else if (s.os_cnt == serial_port_pkg::START_MID)
          begin
            n.rx_st = RX_DATA;
            n.os_cnt = 4'h0;
            n.bit_cnt = 3'h0;
          end
          else
            n.os_cnt = s.os_cnt + 4'h1;
        end
        RX_DATA:
        begin
          n.os_cnt = s.os_cnt + 4'h1;
          if (s.os_cnt == serial_port_pkg::OS_LAST)
          begin
            n.rx_sh = {s.rx_line, s.rx_sh[7:1]};
            n.bit_cnt = s.bit_cnt + 3'h1;
            if (s.bit_cnt == serial_port_pkg::DATA_LAST)
              n.rx_st = RX_STOP;
          end
        end
        RX_STOP:
        begin
          n.os_cnt = s.os_cnt + 4'h1;
          if (s.os_cnt == serial_port_pkg::OS_LAST)
          begin
            n.rx_st = RX_IDLE;
            n.idle_armed = 1'b1;
            n.idle_cnt = 8'h00;
            wake = mute & s.ctrl_a[serial_port_pkg::CA_WAKE_SEL]
                   & s.rx_sh[7];
            if (wake)
              n.ctrl_b[serial_port_pkg::CB_RX_MUTE] = 1'b0;  // see RULE_10
            if (~mute | wake)
            begin
              if (s.rx_full_flag)
                n.ovr = 1'b1;
              else
              begin
                n.rx_buf = s.rx_sh;  // see RULE_12
                n.rx_full_flag = 1'b1;
                n.fe = ~s.rx_line;
              end
            end
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s <= '0;
      s.ctrl_a <= serial_port_pkg::CTRL_RST;
      s.ctrl_b <= serial_port_pkg::CTRL_RST;
      s.baud <= serial_port_pkg::BAUD_RST;
      s.rx_ext <= serial_port_pkg::EXT_RST;  // see RULE_17
      s.tx_ext <= serial_port_pkg::EXT_RST;
      s.tx_buffer_empty_flag <= 1'b1;
      s.tc <= 1'b1;
      s.rx_sync <= 3'h7;
      s.rx_line <= 1'b1;
      s.tx_q <= 1'b1;
      s.tx_st <= TX_OFF;
      s.rx_st <= RX_IDLE;
    end
    else if (ce)
      s <= n;
  end

endmodule

// file: tb/serial_peer.sv
/*
 * Remote serial peer: sends frames on rxd and decodes frames on line.
 * Assumes line is pulled high while the port does not drive it.
 */
`timescale 1ns/1ps
module serial_peer (
  input  wire logic pclk,
  input  wire logic line,
  output logic      rxd
);
  initial rxd = 1'b1;

  // Start 0, eight data bits LSB first, stop 1 that stays as idle
  task automatic send(input logic [7:0] b, input int bt);
    for (int i = 0; i < 10; i++)
    begin
      rxd <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i - 1];
      repeat (bt) @(posedge pclk);
    end
  endtask

  // Bit 0 of the byte must be 1 so the start bit can be timed
  task automatic recv(output logic [7:0] b, output int w);
    w = 0;
    @(negedge line);
    @(negedge pclk);
    while (line === 1'b0)
    begin
      w++;
      @(negedge pclk);
    end
    repeat (w / 2) @(negedge pclk);
    for (int i = 0; i < 8; i++)
    begin
      b[i] = line;
      repeat (w) @(negedge pclk);
    end
  endtask
endmodule

// file: tb/serial_port_assertions.sv
/*
 * Checker for serial_port: shadows control registers from APB writes
 * and watches the pins. Assumes ce high and fast baud in the bench.
 */
`timescale 1ns/1ps
module serial_port_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        ce,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        rxd_pin,
  input wire logic        txd_out,
  input wire logic        txd_oe,
  input wire logic        irq
);
  logic [7:0] cb_q, br_q, rx_q, tx_q, exp_rd, msk, idx;
  logic       ever_q, acc, mapped, drv;

  assign idx    = paddr[9:2];
  assign acc    = psel && penable && pready;
  assign drv    = ever_q && (cb_q[3] || cb_q[2]);
  assign msk    = (idx == serial_port_pkg::IDX_CTRL_B) ? 8'hfd : 8'hff;
  assign mapped = paddr[11:10] == 2'h0 && idx != 8'h56
    && idx >= serial_port_pkg::IDX_STATUS
    && idx <= serial_port_pkg::IDX_TX_EXT;

  always_comb
  begin
    case (idx)
      serial_port_pkg::IDX_CTRL_B: exp_rd = cb_q;
      serial_port_pkg::IDX_BAUD:   exp_rd = br_q;
      serial_port_pkg::IDX_RX_EXT: exp_rd = rx_q;
      default:                     exp_rd = tx_q;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cb_q   <= 8'h00;
      br_q   <= 8'h00;
      rx_q   <= 8'h00;
      tx_q   <= 8'h00;
      ever_q <= 1'b0;
    end
    else if (acc && pwrite && mapped)
    begin
      if (idx == serial_port_pkg::IDX_CTRL_B)
        cb_q <= pwdata[7:0];
      if (idx == serial_port_pkg::IDX_CTRL_B)
        ever_q <= ever_q | pwdata[3];
      if (idx == serial_port_pkg::IDX_BAUD)
        br_q <= pwdata[7:0];
      if (idx == serial_port_pkg::IDX_RX_EXT)
        rx_q <= pwdata[7:0];
      if (idx == serial_port_pkg::IDX_TX_EXT)
        tx_q <= pwdata[7:0];
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_reset_idle: assert property ($rose(presetn) |->
    txd_out && !txd_oe && !irq && !pready) else $error("bad reset pins");
  a_zero_wait: assert property (psel && !penable && ce ##1
    psel && penable && ce |-> pready) else $error("pready late");
  a_unmapped_err: assert property (acc |->
    pslverr == !mapped && (mapped || pwrite || prdata == 32'h0))
    else $error("unmapped access answer wrong");
  a_reg_readback: assert property (acc && !pwrite &&
    (idx == serial_port_pkg::IDX_CTRL_B || idx == serial_port_pkg::IDX_BAUD
    || idx == serial_port_pkg::IDX_RX_EXT || idx == serial_port_pkg::IDX_TX_EXT)
    |-> (prdata & {24'hffffff, msk}) == {24'h0, exp_rd & msk})
    else $error("register read back wrong");
  a_irq_gated: assert property (cb_q[7:4] == 4'h0 |->
    ##[0:1] !irq) else $error("irq without enable");
  a_pin_driven: assert property (drv |-> ##[0:1] txd_oe)
    else $error("pin not driven");
  a_pin_released: assert property (!drv |-> ##[0:1] !txd_oe)
    else $error("pin not released");
  a_first_wait: assert property ($rose(ever_q) |->
    txd_out[*8] ##1 txd_out[*8]) else $error("start before one bit");
  a_tx_off_idle: assert property (!ever_q |-> txd_out)
    else $error("line active before enable");
  a_break_low: assert property ($rose(cb_q[0]) && cb_q[3] |->
    ##[1:400] !txd_out) else $error("no break on line");

  c_unmapped: cover property (acc && pslverr);
  c_irq: cover property ($rose(irq));
  c_break: cover property ($fell(txd_out) && cb_q[0]);
endmodule

bind serial_port serial_port_checker chk_i (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .rxd_pin(rxd_pin), .txd_out(txd_out), .txd_oe(txd_oe), .irq(irq)
);

// file: tb/testbench.sv
/*
 * Self-checking bench for serial_port: APB master task, one task per
 * scenario, serial_peer on the line. Assumes ce tied high.
 */
`timescale 1ns/1ps
module testbench;
  localparam logic [7:0] ST = serial_port_pkg::IDX_STATUS;
  localparam logic [7:0] DR = serial_port_pkg::IDX_DATA;
  localparam logic [7:0] BR = serial_port_pkg::IDX_BAUD;
  localparam logic [7:0] CB = serial_port_pkg::IDX_CTRL_B;
  localparam logic [7:0] RX = serial_port_pkg::IDX_RX_EXT;
  localparam logic [7:0] TX = serial_port_pkg::IDX_TX_EXT;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        rxd_pin, txd_out, txd_oe, irq, line, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [7:0]  b;
  int          errors, n_tests, cyc, w;

  // Idle line is pulled high while the port releases it
  assign line = txd_oe ? txd_out : 1'b1;

  serial_port uut (
    .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxd_pin(rxd_pin), .txd_out(txd_out), .txd_oe(txd_oe), .irq(irq)
  );
  serial_peer peer (.pclk(pclk), .line(line), .rxd(rxd_pin));

  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      test_done;
    end
  end

  task automatic test_done;
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, e);
    n_tests++;
    if (s !== e)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] i, d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {2'h0, i, 2'h0};
    pwdata  <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    // Request stands until pready is seen high at a rising edge
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    r       = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic t_reset;
    logic [7:0] rg [4] = '{CB, BR, RX, TX};
    @(negedge pclk);
    chk("txd_oe", txd_oe, 1'b0);
    chk("irq", irq, 1'b0);
    apb(0, ST, 8'h00);
    chk("status", r, 32'hc0);
    foreach (rg[i])
    begin
      apb(0, rg[i], 8'h00);
      chk("reset value", r, 32'h0);
    end
    apb(0, 8'h56, 8'h00);
    chk("unmapped err", err, 1'b1);
  endtask

  task automatic t_irq;
    logic [7:0] en [4] = '{8'h80, 8'h40, 8'h20, 8'h10};
    logic       ex [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
    foreach (en[i])
    begin
      apb(1, CB, en[i]);
      @(negedge pclk);
      chk("irq", irq, ex[i]);
    end
  endtask

  task automatic t_tx;
    logic [7:0] br [6] = '{8'h00, 8'h40, 8'h80, 8'hc0, 8'h08, 8'h00};
    logic [7:0] ex [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03};
    int         bt [6] = '{16, 48, 64, 208, 32, 48};
    apb(1, CB, 8'h08);
    repeat (2) @(negedge pclk);
    chk("txd_oe", txd_oe, 1'b1);
    foreach (bt[i])
    begin
      apb(1, BR, br[i]);
      apb(1, TX, ex[i]);
      apb(1, DR, 8'ha5);
      peer.recv(b, w);
      chk("tx byte", b, 8'ha5);
      chk("bit time", w, bt[i]);
    end
  endtask

  task automatic t_pre;
    int t0;
    apb(1, TX, 8'h00);
    apb(1, CB, 8'h0c);
    apb(1, DR, 8'hff);
    wait (line === 1'b0);
    t0 = cyc;
    apb(1, DR, 8'h5a);
    apb(1, CB, 8'h04);
    apb(1, CB, 8'h0c);
    repeat (170) @(negedge pclk);
    wait (line === 1'b0);
    chk("preamble gap", cyc - t0 >= 300, 1'b1);
    repeat (200) @(posedge pclk);
  endtask

  task automatic t_rx;
    apb(1, BR, 8'h01);
    apb(1, RX, 8'h02);
    apb(1, CB, 8'h20);
    peer.send(8'h3c, 64);
    apb(0, ST, 8'h00);
    chk("rx off full", r[5], 1'b0);
    apb(1, CB, 8'h24);
    peer.send(8'h3c, 64);
    repeat (8) @(posedge pclk);
    @(negedge pclk);
    chk("rx irq", irq, 1'b1);
    apb(0, ST, 8'h00);
    chk("rx full", r[5], 1'b1);
    apb(0, DR, 8'h00);
    chk("rx byte", r, 32'h3c);
    apb(0, ST, 8'h00);
    chk("rx full cleared", r[5], 1'b0);
    apb(1, CB, 8'h14);
    repeat (700) @(posedge pclk);
    @(negedge pclk);
    chk("idle irq", irq, 1'b1);
    apb(0, ST, 8'h00);
    apb(0, DR, 8'h00);
    @(negedge pclk);
    chk("idle cleared", irq, 1'b0);
  endtask

  task automatic t_mute;
    apb(1, CB, 8'h06);
    peer.send(8'h77, 64);
    repeat (8) @(posedge pclk);
    apb(0, ST, 8'h00);
    chk("muted full", r[5], 1'b0);
    apb(0, CB, 8'h00);
    chk("mute held", r[1], 1'b1);
    repeat (700) @(posedge pclk);
    apb(0, CB, 8'h00);
    chk("mute woken", r[1], 1'b0);
    // Address mark wakeup: bit 7 of the received byte ends mute
    apb(1, serial_port_pkg::IDX_CTRL_A, 8'h08);
    apb(1, CB, 8'h06);
    peer.send(8'h81, 64);
    repeat (8) @(posedge pclk);
    apb(0, CB, 8'h00);
    chk("mark woken", r[1], 1'b0);
    apb(0, ST, 8'h00);
    chk("mark kept", r[5], 1'b1);
  endtask

  task automatic t_break;
    apb(1, CB, 8'h09);
    repeat (300) @(posedge pclk);
    @(negedge pclk);
    chk("break line", txd_out, 1'b0);
    apb(1, CB, 8'h08);
    repeat (340) @(posedge pclk);
    @(negedge pclk);
    chk("break end", txd_out, 1'b1);
    apb(1, CB, 8'h00);
    @(negedge pclk);
    chk("pin free", txd_oe, 1'b0);
  endtask

  initial
  begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
    errors  = 0;
    n_tests = 0;
    cyc     = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_irq;
    t_tx;
    t_pre;
    t_rx;
    t_mute;
    t_break;
    test_done;
  end
endmodule
